// file: remote_dma_consts.vh
`ifndef REMOTE_DMA_CONSTS_VH
`define REMOTE_DMA_CONSTS_VH

`define CLK_PERIOD_NS 10
`define BIT_TIME_NS 100
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define BIT_CNT_W 4
`define BIT_TMR_LOAD 4'h9

`define FIFO_DEPTH 16
`define FIFO_AW 4
`define FIFO_CW 5

`define ADDR_W 16
`define RESET_ADDR 16'h0000
`define RESET_COUNT 16'h0000
`define RESET_PAGE 8'h00
`define PAGE_OFFSET 8'h00

`define THR_SEL_2 2'h0
`define THR_SEL_4 2'h1
`define THR_SEL_8 2'h2
`define THR_BYTES_2 5'h02
`define THR_BYTES_4 5'h04
`define THR_BYTES_8 5'h08
`define THR_BYTES_12 5'h0c

`define ST_IDLE 3'h0
`define ST_RD_MEM 3'h1
`define ST_RD_CAP 3'h2
`define ST_RD_ACK_HI 3'h3
`define ST_RD_ACK_LO 3'h4
`define ST_WR_ACK_HI 3'h5
`define ST_WR_ACK_LO 3'h6

`endif

// file: tx_byte_fifo.v
`timescale 1ns/1ps
`default_nettype none
`include "remote_dma_consts.vh"

module tx_byte_fifo (
   input wire i_sys_clk,
   input wire i_reset_n,
   input wire i_flush,
   input wire i_push,
   input wire [7:0] i_push_data,
   input wire i_pop,
   output wire [7:0] o_pop_data,
   output wire [`FIFO_CW-1:0] o_count,
   output wire o_full,
   output wire o_empty
);
   reg [7:0] mem_ff [0:`FIFO_DEPTH-1];
   reg [`FIFO_AW-1:0] wr_ptr_ff;
   reg [`FIFO_AW-1:0] rd_ptr_ff;
   reg [`FIFO_CW-1:0] count_ff;
   wire do_push;
   wire do_pop;

   // push is refused when full and pop when empty, so the count never lies
   assign do_push = i_push && !count_ff[`FIFO_AW];
   assign do_pop = i_pop && (count_ff != {`FIFO_CW{1'b0}});
   assign o_pop_data = mem_ff[rd_ptr_ff];
   assign o_count = count_ff;
   assign o_full = count_ff[`FIFO_AW];
   assign o_empty = (count_ff == {`FIFO_CW{1'b0}});

   always @(posedge i_sys_clk) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= i_push_data;
      end
   end

   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr_ff <= {`FIFO_AW{1'b0}};
         rd_ptr_ff <= {`FIFO_AW{1'b0}};
         count_ff <= {`FIFO_CW{1'b0}};
      end else if (i_flush) begin
         wr_ptr_ff <= {`FIFO_AW{1'b0}};
         rd_ptr_ff <= {`FIFO_AW{1'b0}};
         count_ff <= {`FIFO_CW{1'b0}};
      end else begin
         if (do_push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (do_pop && !do_push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

// file: remote_dma_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "remote_dma_consts.vh"

// What this block does
// - frame bytes leave in ascending order, each byte least significant bit first
// - three modes: remote write, remote read, send packet
// - start address pair gives first location, count pair gives bytes to move
// - every remote byte or word uses a full request/acknowledge handshake
// - remote write: port data goes to consecutive memory from start address
// - remote read: consecutive memory from start address goes out on the port
// - each remote transfer increments address and decrements remaining count
// - remote read or write ends as soon as the count reaches zero
// - a 16-byte FIFO with programmable threshold sits between bus and media
// - at threshold the local channel moves that many bytes from memory to FIFO
// - an empty FIFO while the frame still runs is reported as underrun
// - on underrun transmit enable stays active until the jabber stop or the end of the frame ends it
// - send packet loads address from boundary, count from header, then advances boundary
// - send packet reads wrap from the ring stop page to the ring start page
module remote_dma_channel (
   input wire i_sys_clk,
   input wire i_reset_n,
   input wire i_byte_order_select,
   input wire i_word_transfer_select,
   input wire [1:0] i_fifo_threshold,
   input wire [7:0] i_reg_wdata,
   input wire i_remote_start_addr_lo_we,
   input wire i_remote_start_addr_hi_we,
   input wire i_remote_count_lo_we,
   input wire i_remote_count_hi_we,
   input wire i_boundary_we,
   input wire i_cmd_remote_read,
   input wire i_cmd_remote_write,
   input wire i_cmd_send_packet,
   input wire [7:0] i_ring_start_page,
   input wire [7:0] i_ring_stop_page,
   input wire [15:0] i_header_count,
   input wire [7:0] i_next_page_ptr,
   input wire [15:0] i_port_data,
   input wire i_port_ack,
   input wire [15:0] i_mem_rdata,
   input wire i_tx_start,
   input wire [15:0] i_tx_length,
   input wire i_local_bus_ack,
   input wire i_local_valid,
   input wire [7:0] i_local_data,
   input wire i_jabber_stop,
   input wire i_underrun_clr,
   output reg o_port_request,
   output reg [15:0] o_port_data,
   output reg o_port_data_oe,
   output reg o_port_read_strobe,
   output reg [15:0] o_mem_addr,
   output reg [15:0] o_mem_wdata,
   output reg o_mem_word,
   output reg o_memory_write_strobe,
   output reg o_mem_read_strobe,
   output reg [15:0] o_current_remote_addr,
   output reg [15:0] o_remote_count,
   output reg o_remote_busy,
   output reg [7:0] o_ring_boundary_pointer,
   output reg o_local_bus_request,
   output reg o_tx_enable_out,
   output reg o_tx_data,
   output reg o_tx_underrun
);
   function [15:0] lane_order;
      input [15:0] data;
      input byte_order_select;
      begin
         lane_order = byte_order_select ? {data[7:0], data[15:8]} : data;
      end
   endfunction

   function [4:0] thr_bytes;
      input [1:0] sel;
      begin
         case (sel)
            `THR_SEL_2: thr_bytes = `THR_BYTES_2;
            `THR_SEL_4: thr_bytes = `THR_BYTES_4;
            `THR_SEL_8: thr_bytes = `THR_BYTES_8;
            default: thr_bytes = `THR_BYTES_12;
         endcase
      end
   endfunction

   reg ack_meta_ff;
   reg ack_sync_ff;
   reg bus_ack_meta_ff;
   reg bus_ack_sync_ff;
   reg jab_meta_ff;
   reg jab_sync_ff;
   reg [2:0] state_ff;
   reg send_mode_ff;
   reg [15:0] start_addr_ff;
   reg [15:0] start_count_ff;
   reg [15:0] fetch_left_ff;
   reg [4:0] burst_left_ff;
   reg [15:0] send_left_ff;
   reg [7:0] shift_ff;
   reg [3:0] bits_left_ff;
   reg [`BIT_CNT_W-1:0] bit_tmr_ff;
   reg tx_active_ff;
   wire [15:0] step;
   wire count_last;
   wire [15:0] addr_inc;
   wire [15:0] nxt_addr;
   wire [15:0] nxt_count;
   wire [7:0] ring_boundary_pointer_calc;
   wire [4:0] fifo_count;
   wire [7:0] fifo_out;
   wire fifo_empty;
   wire fifo_push;
   wire fifo_pop;
   wire bit_tick;
   wire need_byte;
   wire [4:0] thr;

   // host handshake, bus grant and jabber stop arrive from pins
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_meta_ff <= 1'b0;
         ack_sync_ff <= 1'b0;
         bus_ack_meta_ff <= 1'b0;
         bus_ack_sync_ff <= 1'b0;
         jab_meta_ff <= 1'b0;
         jab_sync_ff <= 1'b0;
      end else begin
         ack_meta_ff <= i_port_ack;
         ack_sync_ff <= ack_meta_ff;
         bus_ack_meta_ff <= i_local_bus_ack;
         bus_ack_sync_ff <= bus_ack_meta_ff;
         jab_meta_ff <= i_jabber_stop;
         jab_sync_ff <= jab_meta_ff;
      end
   end

   assign step = i_word_transfer_select ? 16'h0002 : 16'h0001;
   assign count_last = (o_remote_count <= step);
   assign addr_inc = o_current_remote_addr + step;
   // wrap only matters for ring reads, a plain block move runs straight through
   assign nxt_addr = (send_mode_ff && (addr_inc[15:8] == i_ring_stop_page)) ?
                     {i_ring_start_page, `PAGE_OFFSET} : addr_inc;
   assign nxt_count = count_last ? 16'h0000 : (o_remote_count - step);
   assign ring_boundary_pointer_calc = ((i_next_page_ptr - 8'h01) < i_ring_start_page) ?
                      (i_ring_stop_page - 8'h01) : (i_next_page_ptr - 8'h01);

   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         start_addr_ff <= `RESET_ADDR;
         start_count_ff <= `RESET_COUNT;
      end else begin
         if (i_remote_start_addr_lo_we) begin
            start_addr_ff[7:0] <= i_reg_wdata;
         end
         if (i_remote_start_addr_hi_we) begin
            start_addr_ff[15:8] <= i_reg_wdata;
         end
         if (i_remote_count_lo_we) begin
            start_count_ff[7:0] <= i_reg_wdata;
         end
         if (i_remote_count_hi_we) begin
            start_count_ff[15:8] <= i_reg_wdata;
         end
      end
   end

   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff <= `ST_IDLE;
         send_mode_ff <= 1'b0;
         o_port_request <= 1'b0;
         o_port_data <= 16'h0000;
         o_port_data_oe <= 1'b0;
         o_port_read_strobe <= 1'b0;
         o_mem_addr <= `RESET_ADDR;
         o_mem_wdata <= 16'h0000;
         o_mem_word <= 1'b0;
         o_memory_write_strobe <= 1'b0;
         o_mem_read_strobe <= 1'b0;
         o_current_remote_addr <= `RESET_ADDR;
         o_remote_count <= `RESET_COUNT;
         o_remote_busy <= 1'b0;
         o_ring_boundary_pointer <= `RESET_PAGE;
      end else begin
         o_port_read_strobe <= 1'b0;
         o_memory_write_strobe <= 1'b0;
         o_mem_read_strobe <= 1'b0;
         if (i_boundary_we && state_ff == `ST_IDLE) begin
            o_ring_boundary_pointer <= i_reg_wdata;
         end
         case (state_ff)
            `ST_IDLE: begin
               o_remote_busy <= 1'b0;
               // commands during a transfer are ignored
               if (i_cmd_send_packet) begin
                  o_current_remote_addr <= {o_ring_boundary_pointer, `PAGE_OFFSET};
                  o_remote_count <= i_header_count;
                  send_mode_ff <= 1'b1;
                  o_remote_busy <= (i_header_count != 16'h0000);
                  state_ff <= (i_header_count != 16'h0000) ? `ST_RD_MEM : `ST_IDLE;
               end else if (i_cmd_remote_read || i_cmd_remote_write) begin
                  o_current_remote_addr <= start_addr_ff;
                  o_remote_count <= start_count_ff;
                  send_mode_ff <= 1'b0;
                  if (start_count_ff != 16'h0000) begin
                     o_remote_busy <= 1'b1;
                     if (i_cmd_remote_write) begin
                        o_port_request <= 1'b1;
                        state_ff <= `ST_WR_ACK_HI;
                     end else begin
                        state_ff <= `ST_RD_MEM;
                     end
                  end
               end
            end
            `ST_RD_MEM: begin
               o_mem_addr <= o_current_remote_addr;
               o_mem_word <= i_word_transfer_select;
               o_mem_read_strobe <= 1'b1;
               state_ff <= `ST_RD_CAP;
            end
            `ST_RD_CAP: begin
               if (!o_mem_read_strobe) begin
                  o_port_data <= lane_order(i_mem_rdata, i_byte_order_select);
                  o_port_data_oe <= 1'b1;
                  o_port_request <= 1'b1;
                  state_ff <= `ST_RD_ACK_HI;
               end
            end
            `ST_RD_ACK_HI: begin
               if (ack_sync_ff) begin
                  o_port_request <= 1'b0;
                  o_current_remote_addr <= nxt_addr;
                  o_remote_count <= nxt_count;
                  state_ff <= `ST_RD_ACK_LO;
               end
            end
            `ST_RD_ACK_LO: begin
               if (!ack_sync_ff) begin
                  o_port_data_oe <= 1'b0;
                  if (o_remote_count == 16'h0000) begin
                     state_ff <= `ST_IDLE;
                     o_remote_busy <= 1'b0;
                     if (send_mode_ff) begin
                        o_ring_boundary_pointer <= ring_boundary_pointer_calc;
                     end
                  end else begin
                     state_ff <= `ST_RD_MEM;
                  end
               end
            end
            `ST_WR_ACK_HI: begin
               if (ack_sync_ff) begin
                  o_port_request <= 1'b0;
                  o_port_read_strobe <= 1'b1;
                  o_mem_addr <= o_current_remote_addr;
                  o_mem_wdata <= lane_order(i_port_data, i_byte_order_select);
                  o_mem_word <= i_word_transfer_select;
                  o_memory_write_strobe <= 1'b1;
                  o_current_remote_addr <= addr_inc;
                  o_remote_count <= nxt_count;
                  state_ff <= `ST_WR_ACK_LO;
               end
            end
            `ST_WR_ACK_LO: begin
               if (!ack_sync_ff) begin
                  if (o_remote_count == 16'h0000) begin
                     state_ff <= `ST_IDLE;
                     o_remote_busy <= 1'b0;
                  end else begin
                     o_port_request <= 1'b1;
                     state_ff <= `ST_WR_ACK_HI;
                  end
               end
            end
            default: begin
               state_ff <= `ST_IDLE;
               o_port_request <= 1'b0;
               o_port_data_oe <= 1'b0;
            end
         endcase
      end
   end

   assign thr = thr_bytes(i_fifo_threshold);
   assign fifo_push = o_local_bus_request && bus_ack_sync_ff && i_local_valid &&
                      (burst_left_ff != 5'h00);
   assign bit_tick = (bit_tmr_ff == 4'h0);
   assign need_byte = tx_active_ff && bit_tick && (bits_left_ff == 4'h0) &&
                      (send_left_ff != 16'h0000);
   assign fifo_pop = need_byte && !fifo_empty;

   tx_byte_fifo u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_flush(i_tx_start),
      .i_push(fifo_push),
      .i_push_data(i_local_data),
      .i_pop(fifo_pop),
      .o_pop_data(fifo_out),
      .o_count(fifo_count),
      .o_full(),
      .o_empty(fifo_empty)
   );

   // a burst is only started when the whole threshold fits, so a push never meets a full FIFO
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fetch_left_ff <= 16'h0000;
         burst_left_ff <= 5'h00;
         o_local_bus_request <= 1'b0;
      end else if (i_tx_start) begin
         fetch_left_ff <= i_tx_length;
         burst_left_ff <= 5'h00;
         o_local_bus_request <= 1'b0;
      end else if (!o_local_bus_request) begin
         if (fetch_left_ff != 16'h0000 && (5'h10 - fifo_count) >= thr) begin
            o_local_bus_request <= 1'b1;
            burst_left_ff <= thr;
         end
      end else if (fifo_push) begin
         fetch_left_ff <= fetch_left_ff - 16'h0001;
         burst_left_ff <= burst_left_ff - 5'h01;
         if (burst_left_ff == 5'h01 || fetch_left_ff == 16'h0001) begin
            o_local_bus_request <= 1'b0;
         end
      end
   end

   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tx_active_ff <= 1'b0;
         send_left_ff <= 16'h0000;
         shift_ff <= 8'h00;
         bits_left_ff <= 4'h0;
         bit_tmr_ff <= {`BIT_CNT_W{1'b0}};
         o_tx_enable_out <= 1'b0;
         o_tx_data <= 1'b0;
         o_tx_underrun <= 1'b0;
      end else begin
         if (i_underrun_clr) begin
            o_tx_underrun <= 1'b0;
         end
         if (i_tx_start) begin
            tx_active_ff <= (i_tx_length != 16'h0000);
            send_left_ff <= i_tx_length;
            bits_left_ff <= 4'h0;
            bit_tmr_ff <= {`BIT_CNT_W{1'b0}};
         end else if (tx_active_ff) begin
            bit_tmr_ff <= bit_tick ? `BIT_TMR_LOAD :
                          (bit_tmr_ff - 1'b1);
            if (bit_tick) begin
               if (bits_left_ff != 4'h0) begin
                  o_tx_data <= shift_ff[0];
                  shift_ff <= {1'b0, shift_ff[7:1]};
                  bits_left_ff <= bits_left_ff - 4'h1;
               end else if (send_left_ff == 16'h0000) begin
                  tx_active_ff <= 1'b0;
                  o_tx_enable_out <= 1'b0;
               end else if (!fifo_empty) begin
                  o_tx_enable_out <= 1'b1;
                  o_tx_data <= fifo_out[0];
                  shift_ff <= {1'b0, fifo_out[7:1]};
                  bits_left_ff <= 4'h7;
                  send_left_ff <= send_left_ff - 16'h0001;
               end else if (o_tx_enable_out) begin
                  // set wins over a clear in the same cycle
                  o_tx_underrun <= 1'b1;
               end
            end
         end
         // enable is left high after an underrun, only jabber stop or the end of the frame drops it
         if (jab_sync_ff) begin
            tx_active_ff <= 1'b0;
            o_tx_enable_out <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// file: remote_dma_checker.sv
`timescale 1ns/1ps
`default_nettype none
module remote_dma_checker (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_byte_order_select,
   input wire logic i_cmd_remote_read,
   input wire logic i_cmd_remote_write,
   input wire logic i_cmd_send_packet,
   input wire logic [15:0] i_port_data,
   input wire logic i_port_ack,
   input wire logic [15:0] i_mem_rdata,
   input wire logic i_jabber_stop,
   input wire logic i_underrun_clr,
   input wire logic o_port_request,
   input wire logic [15:0] o_port_data,
   input wire logic o_port_data_oe,
   input wire logic o_port_read_strobe,
   input wire logic [15:0] o_mem_addr,
   input wire logic [15:0] o_mem_wdata,
   input wire logic o_mem_word,
   input wire logic o_memory_write_strobe,
   input wire logic o_mem_read_strobe,
   input wire logic [15:0] o_current_remote_addr,
   input wire logic [15:0] o_remote_count,
   input wire logic o_remote_busy,
   input wire logic o_tx_enable_out,
   input wire logic o_tx_underrun
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   wire [15:0] step = o_mem_word ? 16'h0002 : 16'h0001;
   function automatic logic [15:0] lanes(input logic [15:0] d, input logic s);
      return s ? {d[7:0], d[15:8]} : d;
   endfunction
   property p_wr_start;
      i_cmd_remote_write && !i_cmd_send_packet && !o_remote_busy
         |=> o_port_request == (o_remote_count != 16'h0000) && o_remote_busy == o_port_request;
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("write start missed");
   property p_rd_start;
      i_cmd_remote_read && !i_cmd_remote_write && !i_cmd_send_packet && !o_remote_busy
         |-> ##2 o_mem_read_strobe == (o_remote_count != 16'h0000);
   endproperty
   a_rd_start: assert property (p_rd_start) else $error("read start missed");
   property p_rd_data;
      o_mem_read_strobe && o_mem_word |-> ##2 o_port_request && o_port_data_oe
         && o_port_data == lanes($past(i_mem_rdata), i_byte_order_select);
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data wrong");
   property p_req_drop;
      o_port_request && i_port_ack |-> ##[1:4] !o_port_request;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request held");
   property p_wr_pair;
      o_port_read_strobe |-> o_memory_write_strobe && !o_port_request && $past(o_port_request);
   endproperty
   a_wr_pair: assert property (p_wr_pair) else $error("strobe pairing");
   property p_wr_data;
      o_memory_write_strobe && o_mem_word |->
         o_mem_wdata == lanes($past(i_port_data), i_byte_order_select);
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("write data wrong");
   property p_step;
      o_memory_write_strobe |-> o_current_remote_addr == o_mem_addr + step && o_remote_count ==
         (($past(o_remote_count) > step) ? $past(o_remote_count) - step : 16'h0000);
   endproperty
   a_step: assert property (p_step) else $error("address or count step");
   property p_underrun;
      o_tx_underrun && !i_underrun_clr |=> o_tx_underrun;
   endproperty
   a_underrun: assert property (p_underrun) else $error("underrun lost");
   property p_txe_hold;
      o_tx_underrun && o_tx_enable_out && !i_jabber_stop |=> o_tx_enable_out;
   endproperty
   a_txe_hold: assert property (p_txe_hold) else $error("enable dropped");
   c_write: cover property (o_memory_write_strobe && o_mem_word);
   c_swap: cover property (o_mem_read_strobe && i_byte_order_select);
   c_under: cover property ($rose(o_tx_underrun));
endmodule
bind remote_dma_channel remote_dma_checker i_chk (.i_sys_clk, .i_reset_n, .i_byte_order_select,
   .i_cmd_remote_read, .i_cmd_remote_write, .i_cmd_send_packet, .i_port_data, .i_port_ack,
   .i_mem_rdata, .i_jabber_stop, .i_underrun_clr, .o_port_request, .o_port_data,
   .o_port_data_oe, .o_port_read_strobe, .o_mem_addr, .o_mem_wdata, .o_mem_word,
   .o_memory_write_strobe, .o_mem_read_strobe, .o_current_remote_addr, .o_remote_count,
   .o_remote_busy, .o_tx_enable_out, .o_tx_underrun);
`default_nettype wire

// file: host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
   input wire logic i_sys_clk,
   input wire logic i_byte_order_select,
   input wire logic i_word_transfer_select,
   input wire logic i_port_request,
   input wire logic i_port_data_oe,
   input wire logic [15:0] i_port_data,
   output logic o_port_ack,
   output logic [15:0] o_port_data
);
   logic [7:0] frame [0:15];
   logic [15:0] seen [$];
   int idx = 0;
   int delay = 0;
   initial begin
      o_port_ack = 1'h0;
      o_port_data = 16'h5a5a;
   end
   // ack only follows a request; delay makes a slow host
   always begin
      @(posedge i_sys_clk);
      #1;
      if (i_port_request === 1'h1) begin
         if (i_port_data_oe) seen.push_back(i_port_data);
         repeat (delay) @(posedge i_sys_clk);
         #1;
         if (!i_port_data_oe) begin
            if (!i_word_transfer_select) o_port_data = {~o_port_data[15:8], frame[idx]};
            else if (i_byte_order_select) o_port_data = {frame[idx], frame[idx+1]};
            else o_port_data = {frame[idx+1], frame[idx]};
            idx = idx + (i_word_transfer_select ? 2 : 1);
         end
         o_port_ack = 1'h1;
         while (i_port_request === 1'h1) #10;
         o_port_ack = 1'h0;
         // released lines must not keep showing the last word
         o_port_data = ~o_port_data;
      end
   end
endmodule
`default_nettype wire

// file: remote_dma_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module remote_dma_channel_tb_top;
   logic i_sys_clk = 1'h0, i_reset_n = 1'h0, byte_order_select = 1'h0, word_transfer_select = 1'h1, lb_ok = 1'h1;
   logic [1:0] i_fifo_threshold = 2'h0;
   logic [7:0] i_reg_wdata = 8'h00, i_ring_start_page = 8'h40, i_ring_stop_page = 8'h43;
   logic [7:0] i_next_page_ptr = 8'h41, i_local_data = 8'h1e;
   logic [15:0] i_header_count = 16'h0104, i_tx_length = 16'h0040, i_mem_rdata = 16'h0000;
   logic [15:0] i_port_data, o_port_data, o_mem_addr, o_mem_wdata, o_current_remote_addr;
   logic [15:0] o_remote_count;
   logic [4:0] we = 5'h00;
   logic [2:0] cmd = 3'h0;
   logic i_tx_start = 1'h0, i_local_bus_ack = 1'h0, i_local_valid = 1'h0, i_port_ack;
   logic i_jabber_stop = 1'h0, i_underrun_clr = 1'h0;
   logic o_port_request, o_port_data_oe, o_port_read_strobe, o_mem_word, o_memory_write_strobe;
   logic o_mem_read_strobe, o_remote_busy, o_local_bus_request, o_tx_enable_out, o_tx_data;
   logic o_tx_underrun;
   logic [7:0] o_ring_boundary_pointer;
   logic [7:0] mem [0:65535];
   int bad_count = 0, n_compared = 0, cycles = 0;
   remote_dma_channel i_dut (.i_sys_clk, .i_reset_n, .i_byte_order_select(byte_order_select),
      .i_word_transfer_select(word_transfer_select), .i_fifo_threshold, .i_reg_wdata,
      .i_remote_start_addr_lo_we(we[0]), .i_remote_start_addr_hi_we(we[1]),
      .i_remote_count_lo_we(we[2]), .i_remote_count_hi_we(we[3]), .i_boundary_we(we[4]),
      .i_cmd_remote_read(cmd[0]), .i_cmd_remote_write(cmd[1]), .i_cmd_send_packet(cmd[2]),
      .i_ring_start_page, .i_ring_stop_page, .i_header_count, .i_next_page_ptr, .i_port_data,
      .i_port_ack, .i_mem_rdata, .i_tx_start, .i_tx_length, .i_local_bus_ack, .i_local_valid,
      .i_local_data, .i_jabber_stop, .i_underrun_clr, .o_port_request, .o_port_data,
      .o_port_data_oe, .o_port_read_strobe, .o_mem_addr, .o_mem_wdata, .o_mem_word,
      .o_memory_write_strobe, .o_mem_read_strobe, .o_current_remote_addr, .o_remote_count,
      .o_remote_busy, .o_ring_boundary_pointer, .o_local_bus_request, .o_tx_enable_out,
      .o_tx_data, .o_tx_underrun);
   host_port_model i_host (.i_sys_clk, .i_byte_order_select(byte_order_select), .i_word_transfer_select(word_transfer_select),
      .i_port_request(o_port_request), .i_port_data_oe(o_port_data_oe),
      .i_port_data(o_port_data), .o_port_ack(i_port_ack), .o_port_data(i_port_data));
   always #5 i_sys_clk = ~i_sys_clk;
   // buffer memory answers a read strobe one cycle later
   always @(posedge i_sys_clk) begin
      if (o_memory_write_strobe) begin
         mem[o_mem_addr] <= o_mem_wdata[7:0];
         if (o_mem_word) mem[o_mem_addr + 16'h0001] <= o_mem_wdata[15:8];
      end
      if (o_mem_read_strobe) i_mem_rdata <= #1 o_mem_word ?
         {mem[o_mem_addr + 16'h0001], mem[o_mem_addr]} : {2{mem[o_mem_addr]}};
      i_local_bus_ack <= #1 o_local_bus_request & lb_ok;
      i_local_valid <= #1 o_local_bus_request & lb_ok;
   end
   function automatic logic [7:0] mb(input logic [15:0] a);
      return a[7:0] ^ a[15:8];
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic set_reg(input int k, input logic [7:0] d);
      i_reg_wdata = d;
      we = 5'h01 << k;
      tick(1);
      we = 5'h00;
      tick(1);
   endtask
   task automatic load(input logic [15:0] a, input logic [15:0] c);
      set_reg(0, a[7:0]);
      set_reg(1, a[15:8]);
      set_reg(2, c[7:0]);
      set_reg(3, c[15:8]);
   endtask
   task automatic run(input int k);
      int n;
      cmd = 3'h1 << k;
      tick(1);
      cmd = 3'h0;
      tick(3);
      for (n = 0; n < 2000 && o_remote_busy !== 1'h0; n++) tick(4);
      `CHK("busy", 1'h0, o_remote_busy)
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      int st, n;
      logic [15:0] e, g, a;
      for (int i = 0; i < 65536; i++) mem[i] = mb(i[15:0]);
      tick(2);
      i_reset_n = 1'h1;
      tick(1);
      for (int m = 0; m < 3; m++) begin
         byte_order_select = (m == 1);
         word_transfer_select = (m != 2);
         st = word_transfer_select ? 2 : 1;
         i_host.delay = 4 * m;
         i_host.idx = 0;
         for (int k = 0; k < 16; k++) i_host.frame[k] = 8'(8'h30 + 8'h11 * k + m);
         load(16'h0122, 16'h0005);
         run(0);
         load(16'h0123, 16'h0004);
         run(1);
         for (int k = 0; k < 4; k++) `CHK("mem", i_host.frame[k], mem[16'h0123 + k])
         `CHK("addr", 16'h0127, o_current_remote_addr)
         `CHK("count", 16'h0000, o_remote_count)
         i_host.seen.delete();
         load(16'h0123, 16'h0004);
         run(0);
         for (int k = 0; k < 4; k += st) begin
            e = word_transfer_select ? (byte_order_select ? {i_host.frame[k], i_host.frame[k+1]}
               : {i_host.frame[k+1], i_host.frame[k]}) : {8'h00, i_host.frame[k]};
            g = i_host.seen[k / st];
            if (!word_transfer_select) g[15:8] = 8'h00;
            `CHK("port", e, g)
         end
      end
      byte_order_select = 1'h0;
      word_transfer_select = 1'h1;
      i_host.seen.delete();
      set_reg(4, 8'h42);
      set_reg(3, 8'h0f);
      run(2);
      `CHK("words", 130, i_host.seen.size())
      for (int k = 0; k < 130; k++) begin
         a = (k < 128) ? 16'(16'h4200 + 2 * k) : 16'(16'h3f00 + 2 * k);
         `CHK("send", {mb(a + 16'h0001), mb(a)}, i_host.seen[k])
      end
      `CHK("boundary", 8'h40, o_ring_boundary_pointer)
      i_tx_start = 1'h1;
      tick(1);
      i_tx_start = 1'h0;
      for (n = 0; n < 3000 && o_tx_enable_out !== 1'h1; n++) tick(1);
      // withholding the grant starves the fifo on purpose
      lb_ok = 1'h0;
      tick(4);
      for (int b = 0; b < 8; b++) begin
         `CHK("serial", i_local_data[b], o_tx_data)
         tick(10);
      end
      tick(1500);
      `CHK("local_bus_request", 1'h1, o_local_bus_request)
      `CHK("underrun", 1'h1, o_tx_underrun)
      `CHK("enable", 1'h1, o_tx_enable_out)
      i_jabber_stop = 1'h1;
      tick(6);
      `CHK("jabber", 1'h0, o_tx_enable_out)
      i_jabber_stop = 1'h0;
      i_underrun_clr = 1'h1;
      tick(1);
      i_underrun_clr = 1'h0;
      tick(1);
      `CHK("clear", 1'h0, o_tx_underrun)
      wrap_up();
   end
endmodule
`default_nettype wire
